// File: src/flu_regs.svh
// Register offsets, field positions and reset values of the float load unit
`ifndef FLU_REGS_SVH
`define FLU_REGS_SVH
// Register byte offsets
`define FLU_ADDR_CMD 8'h00
`define FLU_ADDR_OPND 8'h04
`define FLU_ADDR_FLAGS 8'h08
`define FLU_ADDR_STAT 8'h0C
`define FLU_ADDR_CTRL 8'h10
`define FLU_ADDR_REGSEL 8'h14
`define FLU_ADDR_REGDAT 8'h18
`define FLU_ADDR_AUX 8'h1C
`define FLU_ADDR_INDEX 8'h20
`define FLU_ADDR_MEMADR 8'h24
`define FLU_ADDR_MEMDAT 8'h28
// Command register fields
`define FLU_CMD_DST1 7:5
`define FLU_CMD_DST2 10:8
`define FLU_CMD_COND 15:11
`define FLU_CMD_IDX1 16
`define FLU_CMD_IDX2 17
`define FLU_CMD_REG2 18
`define FLU_CMD_UPD1 19
`define FLU_CMD_UPD2 20
// Condition flag positions
`define FLU_F_C 0
`define FLU_F_V 1
`define FLU_F_Z 2
`define FLU_F_N 3
`define FLU_F_UF 4
`define FLU_F_LV 5
`define FLU_F_LUF 6
// Float word: exponent 31:24, sign 23; this exponent marks zero
`define FLU_ZERO_EXP 8'h80
`define FLU_SIGN_BIT 23
// Status bits
`define FLU_S_BUSY 0
`define FLU_S_ERR 1
`define FLU_S_WAIT 2
// Bus responses and reset value
`define FLU_RESP_OKAY 2'b00
`define FLU_RESP_SLVERR 2'b10
`define FLU_RST_WORD 32'h0000_0000
`endif

// File: src/flu_pkg.sv
// Types of the float load unit
package flu_pkg;
  // Instruction forms
  typedef enum logic [2:0] {
    FLU_OP_LOAD, FLU_OP_COND, FLU_OP_UNCOND, FLU_OP_ILOCK, FLU_OP_DUAL, FLU_OP_LDST
  } flu_op_t;
  // Source addressing modes
  typedef enum logic [1:0] {FLU_M_REG, FLU_M_DIRECT, FLU_M_INDIRECT, FLU_M_IMM} flu_mode_t;
  // Execute sequencer
  typedef enum logic [1:0] {FLU_ST_IDLE, FLU_ST_EXEC, FLU_ST_LOCK} flu_state_t;
endpackage

// File: src/flu_float_load_unit.sv
// Float load execution unit with AXI4-Lite register access
// Notes on behaviour
// - Two-bit source mode: register, direct, indirect, immediate
// - Plain load copies float source into R0-R7
// - Flags change only when destination is R0-R7
// - N from sign, UF and V cleared
// - Z set when loaded value is zero
// - Saturation mode bit never affects loads
// - Conditional load writes only when condition true
// - Twenty condition codes tested against current flags
// - Conditional and unconditional loads keep all flags
// - Flags come from register loads or compares
// - Interlocked load signals on external flag pins
// - Interlocked load allows direct and indirect only
// - Interlocked load takes one cycle when pin low
// - Dual load: displacement 0/1 or index, R0-R7
// - Same destination keeps the second load's value
// - Later revision allows register second source
// - Load and store same location: read first
// - Read operands at start, write at end
`timescale 1ns/10ps
`default_nettype none
`include "flu_regs.svh"
module flu_float_load_unit #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic external_flag_pin_b,
  output logic external_flag_pin_a
);
  logic [31:0] rf [0:7]; // Extended-precision registers R0-R7
  logic [31:0] mem [0:255]; // Data memory seen by loads and stores
  logic [6:0] flags; // Condition flags
  logic [31:0] cmd_q, opnd_q; // Instruction and operand fields
  logic [1:0] ctrl_q; // Bit 0 saturation mode, bit 1 later revision
  logic [2:0] regsel_q;
  logic [7:0] aux_a, aux_b, index_a, index_b, memadr_q;
  logic err_q; // Sticky illegal-form flag
  flu_pkg::flu_state_t st;
  logic xf_b_m, xf_b_s; // Pin b synchroniser
  logic aw_hold, w_hold;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q, wmask;
  logic wr_fire, wr_hit;
  flu_pkg::flu_op_t op;
  flu_pkg::flu_mode_t mode;
  logic [2:0] dst1, dst2;
  logic idx1, idx2, reg2, par, ilk, legal, cond_ok, commit;
  logic [7:0] fa, fb, addr_a, addr_b;
  logic [31:0] imm, val_a, val_b;

  // Flatten a 20-entry condition table against the flags
  function automatic logic cond_eval(input logic [4:0] c, input logic [6:0] f);
    case (c)
      5'h00: cond_eval = 1'b1;
      5'h01: cond_eval = f[`FLU_F_C];
      5'h02: cond_eval = f[`FLU_F_C] | f[`FLU_F_Z];
      5'h03: cond_eval = ~f[`FLU_F_C] & ~f[`FLU_F_Z];
      5'h04: cond_eval = ~f[`FLU_F_C];
      5'h05: cond_eval = f[`FLU_F_Z];
      5'h06: cond_eval = ~f[`FLU_F_Z];
      5'h07: cond_eval = f[`FLU_F_N];
      5'h08: cond_eval = f[`FLU_F_N] | f[`FLU_F_Z];
      5'h09: cond_eval = ~f[`FLU_F_N] & ~f[`FLU_F_Z];
      5'h0A: cond_eval = ~f[`FLU_F_N];
      5'h0B: cond_eval = ~f[`FLU_F_V];
      5'h0C: cond_eval = f[`FLU_F_V];
      5'h0D: cond_eval = ~f[`FLU_F_UF];
      5'h0E: cond_eval = f[`FLU_F_UF];
      5'h0F: cond_eval = ~f[`FLU_F_LV];
      5'h10: cond_eval = f[`FLU_F_LV];
      5'h11: cond_eval = ~f[`FLU_F_LUF];
      5'h12: cond_eval = f[`FLU_F_LUF];
      5'h13: cond_eval = f[`FLU_F_Z] | f[`FLU_F_UF];
      default: cond_eval = 1'b0; // Codes past the table never pass
    endcase
  endfunction

  // Field decode of the held instruction
  always_comb
  begin
    op = flu_pkg::flu_op_t'(cmd_q[2:0]);
    mode = flu_pkg::flu_mode_t'(cmd_q[4:3]);
    dst1 = cmd_q[`FLU_CMD_DST1];
    dst2 = cmd_q[`FLU_CMD_DST2];
    idx1 = cmd_q[`FLU_CMD_IDX1];
    idx2 = cmd_q[`FLU_CMD_IDX2];
    reg2 = cmd_q[`FLU_CMD_REG2];
    fa = opnd_q[7:0];
    fb = opnd_q[15:8];
    par = (op == flu_pkg::FLU_OP_DUAL) || (op == flu_pkg::FLU_OP_LDST);
    ilk = (op == flu_pkg::FLU_OP_ILOCK);
    cond_ok = cond_eval(cmd_q[`FLU_CMD_COND], flags);
  end

  // Operand fetch; all reads see values from before this edge
  always_comb
  begin
    addr_a = aux_a + (idx1 ? index_a : fa);
    addr_b = aux_b + (idx2 ? index_b : fb);
    // Short float immediate widened to the 32-bit float word
    imm = {{4{opnd_q[31]}}, opnd_q[31:27], opnd_q[26:16], 12'h000};
    val_a = mem[addr_a];
    if (par)
    begin
      if (op == flu_pkg::FLU_OP_LDST && reg2)
        val_a = rf[fa[2:0]];
    end
    else
    begin
      case (mode)
        flu_pkg::FLU_M_REG: val_a = rf[fa[2:0]];
        flu_pkg::FLU_M_DIRECT: val_a = mem[fa];
        flu_pkg::FLU_M_INDIRECT: val_a = mem[addr_a];
        default: val_a = imm;
      endcase
    end
    val_b = reg2 ? rf[fb[2:0]] : mem[addr_b];
  end

  // Form checks; an illegal form only raises the error flag
  always_comb
  begin
    legal = 1'b1;
    if (ilk)
      legal = (mode == flu_pkg::FLU_M_DIRECT) || (mode == flu_pkg::FLU_M_INDIRECT);
    else if (par)
    begin
      legal = idx1 || (fa <= 8'h01);
      if (reg2)
        legal = legal && ctrl_q[1];
      if (op == flu_pkg::FLU_OP_LDST || !reg2)
        legal = legal && (idx2 || (fb <= 8'h01));
    end
    else if (cmd_q[2:0] > 3'h5)
      legal = 1'b0;
    // Finish now unless the interlock is held off by pin b
    commit = legal && !(ilk && xf_b_s) && (st == flu_pkg::FLU_ST_EXEC);
    if (st == flu_pkg::FLU_ST_LOCK)
      commit = !xf_b_s;
  end

  // Two-flop synchroniser for the external pin
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      xf_b_m <= 1'b0;
      xf_b_s <= 1'b0;
    end
    else
    begin
      xf_b_m <= external_flag_pin_b;
      xf_b_s <= xf_b_m;
    end
  end

  // Execute sequencer; pin a marks an interlocked access in flight
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st <= flu_pkg::FLU_ST_IDLE;
      external_flag_pin_a <= 1'b0;
    end
    else
    begin
      case (st)
        flu_pkg::FLU_ST_IDLE:
        begin
          if (wr_hit && aw_addr_q == `FLU_ADDR_CMD)
          begin
            st <= flu_pkg::FLU_ST_EXEC;
            external_flag_pin_a <= (w_data_q[2:0] == 3'h3);
          end
        end
        flu_pkg::FLU_ST_EXEC:
        begin
          if (legal && ilk && xf_b_s)
            st <= flu_pkg::FLU_ST_LOCK;
          else
          begin
            st <= flu_pkg::FLU_ST_IDLE;
            external_flag_pin_a <= 1'b0;
          end
        end
        flu_pkg::FLU_ST_LOCK:
        begin
          if (commit)
          begin
            st <= flu_pkg::FLU_ST_IDLE;
            external_flag_pin_a <= 1'b0;
          end
        end
        default: st <= flu_pkg::FLU_ST_IDLE;
      endcase
    end
  end

  // Register file; results land at the end of the cycle, second load last
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < 8; i++)
        rf[i] <= `FLU_RST_WORD;
    end
    else if (commit)
    begin
      if (op != flu_pkg::FLU_OP_COND || cond_ok)
        rf[dst1] <= val_a;
      if (op == flu_pkg::FLU_OP_DUAL)
        rf[dst2] <= val_b;
    end
    else if (wr_hit && aw_addr_q == `FLU_ADDR_REGDAT)
      rf[regsel_q] <= (rf[regsel_q] & ~wmask) | (w_data_q & wmask);
  end

  // Data memory; the store reads its register before this edge
  always_ff @(posedge clk)
  begin
    if (commit && op == flu_pkg::FLU_OP_LDST)
      mem[addr_b] <= rf[dst2];
    else if (wr_hit && aw_addr_q == `FLU_ADDR_MEMDAT)
      mem[memadr_q] <= w_data_q;
  end

  // Condition flags; software writes stand in for compare results
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      flags <= 7'h00;
    else if (commit && (op == flu_pkg::FLU_OP_LOAD || ilk))
    begin
      // Every destination index is R0-R7, so loads always update
      flags[`FLU_F_N] <= val_a[`FLU_SIGN_BIT];
      flags[`FLU_F_Z] <= (val_a[31:24] == `FLU_ZERO_EXP);
      flags[`FLU_F_UF] <= 1'b0;
      flags[`FLU_F_V] <= 1'b0;
    end
    else if (wr_hit && aw_addr_q == `FLU_ADDR_FLAGS && !commit)
      flags <= w_data_q[6:0];
  end

  // Setup registers; aux update happens even when the condition fails
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cmd_q <= `FLU_RST_WORD;
      opnd_q <= `FLU_RST_WORD;
      ctrl_q <= 2'b00;
      regsel_q <= 3'h0;
      {aux_b, aux_a} <= 16'h0000;
      {index_b, index_a} <= 16'h0000;
      memadr_q <= 8'h00;
    end
    else
    begin
      if (wr_hit)
      begin
        case (aw_addr_q)
          `FLU_ADDR_CMD: if (st == flu_pkg::FLU_ST_IDLE) cmd_q <= w_data_q;
          `FLU_ADDR_OPND: if (st == flu_pkg::FLU_ST_IDLE) opnd_q <= w_data_q;
          `FLU_ADDR_CTRL: ctrl_q <= w_data_q[1:0];
          `FLU_ADDR_REGSEL: regsel_q <= w_data_q[2:0];
          `FLU_ADDR_AUX: {aux_b, aux_a} <= w_data_q[15:0];
          `FLU_ADDR_INDEX: {index_b, index_a} <= w_data_q[15:0];
          `FLU_ADDR_MEMADR: memadr_q <= w_data_q[7:0];
          default: ;
        endcase
      end
      if (commit && cmd_q[`FLU_CMD_UPD1] && (par || mode == flu_pkg::FLU_M_INDIRECT))
        aux_a <= addr_a;
      if (commit && cmd_q[`FLU_CMD_UPD2] && par)
        aux_b <= addr_b;
    end
  end

  // Sticky error; a new illegal form wins over the clearing write
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      err_q <= 1'b0;
    else if (st == flu_pkg::FLU_ST_EXEC && !legal)
      err_q <= 1'b1;
    else if (wr_hit && aw_addr_q == `FLU_ADDR_STAT && w_data_q[`FLU_S_ERR])
      err_q <= 1'b0;
  end

  // Write channel: address and data held in either order
  assign wr_fire = aw_hold && w_hold && !s_axi_bvalid;
  // Words past the last register answer with an error and change nothing
  assign wr_hit = wr_fire && (aw_addr_q <= 8'h28);
  assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}},
                  {8{s_axi_wstrb[0]}}};
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= `FLU_RST_WORD;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FLU_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold <= 1'b1;
        aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold <= 1'b1;
        w_data_q <= s_axi_wdata & wmask;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_q <= 8'h28) ? `FLU_RESP_OKAY : `FLU_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read channel: one read at a time, answered one cycle after address
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `FLU_RST_WORD;
      s_axi_rresp <= `FLU_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `FLU_RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        `FLU_ADDR_CMD: s_axi_rdata <= cmd_q;
        `FLU_ADDR_OPND: s_axi_rdata <= opnd_q;
        `FLU_ADDR_FLAGS: s_axi_rdata <= {25'h0, flags};
        `FLU_ADDR_STAT: s_axi_rdata <= {29'h0, st == flu_pkg::FLU_ST_LOCK, err_q,
                                        st != flu_pkg::FLU_ST_IDLE};
        `FLU_ADDR_CTRL: s_axi_rdata <= {30'h0, ctrl_q};
        `FLU_ADDR_REGSEL: s_axi_rdata <= {29'h0, regsel_q};
        `FLU_ADDR_REGDAT: s_axi_rdata <= rf[regsel_q];
        `FLU_ADDR_AUX: s_axi_rdata <= {16'h0, aux_b, aux_a};
        `FLU_ADDR_INDEX: s_axi_rdata <= {16'h0, index_b, index_a};
        `FLU_ADDR_MEMADR: s_axi_rdata <= {24'h0, memadr_q};
        `FLU_ADDR_MEMDAT: s_axi_rdata <= mem[memadr_q];
        default:
        begin
          s_axi_rdata <= `FLU_RST_WORD;
          s_axi_rresp <= `FLU_RESP_SLVERR; // Unmapped word
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Checks of the execute path
  property p_cond_false_keeps;
    @(posedge clk) disable iff (!reset_n)
    commit && op == flu_pkg::FLU_OP_COND && !cond_ok |=> rf[$past(dst1)] == $past(rf[dst1]);
  endproperty
  a_cond_false_keeps: assert property (p_cond_false_keeps) else $error("false cond wrote");
  property p_flags_kept;
    @(posedge clk) disable iff (!reset_n)
    commit && (par || op == flu_pkg::FLU_OP_COND || op == flu_pkg::FLU_OP_UNCOND)
    |=> $stable(flags);
  endproperty
  a_flags_kept: assert property (p_flags_kept) else $error("flags changed");
  property p_load_nz;
    @(posedge clk) disable iff (!reset_n)
    commit && op == flu_pkg::FLU_OP_LOAD |=> flags[`FLU_F_N] == $past(val_a[23])
      && flags[`FLU_F_Z] == ($past(val_a[31:24]) == `FLU_ZERO_EXP);
  endproperty
  a_load_nz: assert property (p_load_nz) else $error("N or Z wrong");
  property p_load_clears;
    @(posedge clk) disable iff (!reset_n)
    commit && (op == flu_pkg::FLU_OP_LOAD || ilk) |=> !flags[`FLU_F_UF] && !flags[`FLU_F_V]
      && flags[6:5] == $past(flags[6:5]) && flags[0] == $past(flags[0]);
  endproperty
  a_load_clears: assert property (p_load_clears) else $error("UF/V/held flags wrong");
  property p_ilock_one;
    @(posedge clk) disable iff (!reset_n)
    st == flu_pkg::FLU_ST_EXEC && ilk && legal && !xf_b_s
    |=> st == flu_pkg::FLU_ST_IDLE && !external_flag_pin_a;
  endproperty
  a_ilock_one: assert property (p_ilock_one) else $error("interlock not single");
  property p_ilock_stall;
    @(posedge clk) disable iff (!reset_n)
    st == flu_pkg::FLU_ST_LOCK && xf_b_s |=> st == flu_pkg::FLU_ST_LOCK && external_flag_pin_a;
  endproperty
  a_ilock_stall: assert property (p_ilock_stall) else $error("stall lost");
  property p_ilock_mode;
    @(posedge clk) disable iff (!reset_n)
    st == flu_pkg::FLU_ST_EXEC && ilk && (mode == flu_pkg::FLU_M_REG || mode == flu_pkg::FLU_M_IMM)
    |=> err_q && st == flu_pkg::FLU_ST_IDLE;
  endproperty
  a_ilock_mode: assert property (p_ilock_mode) else $error("bad mode ran");
  property p_dual_same;
    @(posedge clk) disable iff (!reset_n)
    commit && op == flu_pkg::FLU_OP_DUAL && dst1 == dst2 |=> rf[$past(dst2)] == $past(val_b);
  endproperty
  a_dual_same: assert property (p_dual_same) else $error("dual order wrong");
  c_ilock_wait: cover property (@(posedge clk) st == flu_pkg::FLU_ST_LOCK ##1 commit);
  c_cond_true: cover property (@(posedge clk) commit && op == flu_pkg::FLU_OP_COND && cond_ok);
  c_ldst: cover property (@(posedge clk) commit && op == flu_pkg::FLU_OP_LDST);
endmodule
`default_nettype wire

// File: test/flu_ilock_model.sv
// Behavioural model of the external interlock logic that watches the flag pins
`timescale 1ns/10ps
`default_nettype none
module flu_ilock_model #(
  parameter int HOLD = 12
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hold_req,
  input wire logic pin_a,
  output logic pin_b
);
  // Cycles the interlock has been held since pin a rose
  int cnt;

  // Raise pin b ahead of the load so the unit sees it through its synchroniser
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_b <= 1'b0;
      cnt <= 0;
    end
    else if (pin_b && pin_a)
    begin
      // Slow answer: keep the load stalled for a fixed span
      cnt <= cnt + 1;
      if (cnt == HOLD) pin_b <= 1'b0;
    end
    else if (!pin_b && hold_req && !pin_a)
    begin
      // Hold requested: raise pin b before the load starts
      pin_b <= 1'b1;
      cnt <= 0;
    end
  end
endmodule
`default_nettype wire

// File: test/flu_float_load_unit_tb.sv
// Testbench of the float load unit driven over its register bus
`timescale 1ns/10ps
`default_nettype none
`include "flu_regs.svh"
module flu_float_load_unit_tb;
  `define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
  // Float words: negative, positive and zero
  localparam logic [31:0] NEG = 32'h0584_C000;
  localparam logic [31:0] POS = 32'h010C_52A0;
  localparam logic [31:0] ZER = 32'h8000_0000;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, hold_req = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pin_a, pin_b;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, v, fv;
  int error_cnt = 0;
  int checked = 0;
  int n;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  flu_float_load_unit flu_float_load_unit_inst (.clk(clk), .reset_n(reset_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .external_flag_pin_b(pin_b), .external_flag_pin_a(pin_a));

  // Hold long enough to observe the stall over the bus
  flu_ilock_model #(.HOLD(30)) flu_ilock_model_inst (.clk(clk), .reset_n(reset_n),
    .hold_req(hold_req), .pin_a(pin_a), .pin_b(pin_b));

  // Verdict and end of run
  task finish_test;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Write one word; handshakes judged from values settled before the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    int k;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    k = 0;
    b = 1'b0;
    while (!b && k < 100)
    begin
      #1;
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      rs = bresp;
      @(posedge clk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      k++;
    end
    bready <= 1'b0;
    if (!b) error_cnt++;
  endtask

  // Read one word into v with its response in rs
  task automatic rd(input logic [7:0] a);
    logic ar, r;
    int k;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    k = 0;
    r = 1'b0;
    while (!r && k < 100)
    begin
      #1;
      ar = arvalid && arready;
      r = rvalid;
      v = rdata;
      rs = rresp;
      @(posedge clk);
      if (ar) arvalid <= 1'b0;
      k++;
    end
    rready <= 1'b0;
    if (!r) error_cnt++;
  endtask

  task automatic rreg(input logic [31:0] i);
    wr(`FLU_ADDR_REGSEL, i);
    rd(`FLU_ADDR_REGDAT);
  endtask

  task automatic setm(input logic [31:0] a, input logic [31:0] d);
    wr(`FLU_ADDR_MEMADR, a);
    wr(`FLU_ADDR_MEMDAT, d);
  endtask

  // Poll busy; n counts status reads, bounded so a hang is cut short
  task automatic poll;
    n = 0;
    do
    begin
      rd(`FLU_ADDR_STAT);
      n++;
    end
    while (v[0] === 1'b1 && n < 60);
    if (v[0] !== 1'b0) error_cnt++;
  endtask

  task automatic exec(input logic [31:0] c, input logic [31:0] o);
    wr(`FLU_ADDR_OPND, o);
    wr(`FLU_ADDR_CMD, c);
    poll;
  endtask

  // Command word; hi holds upd2, upd1, reg2, idx2, idx1
  function automatic logic [31:0] cmd(input logic [2:0] op, input logic [1:0] m,
    input logic [2:0] d1, input logic [2:0] d2, input logic [4:0] c, input logic [4:0] hi);
    return {11'h000, hi, c, d2, d1, m, op};
  endfunction

  // Flags after a flag-updating load: keep LATCHED_UNDERFLOW_FLAG, LV, C; clear UF, V
  function automatic logic [31:0] eflags(input logic [31:0] o, input logic [31:0] x);
    return {25'h0, o[6], o[5], 1'b0, x[23], x[31:24] == 8'h80, 1'b0, o[0]};
  endfunction

  // Condition table as chosen for this unit
  function automatic logic ctrue(input int c, input logic [31:0] f);
    case (c)
      0: return 1'b1;
      1: return f[0];
      2: return f[0] | f[2];
      3: return !f[0] && !f[2];
      4: return !f[0];
      5: return f[2];
      6: return !f[2];
      7: return f[3];
      8: return f[3] | f[2];
      9: return !f[3] && !f[2];
      10: return !f[3];
      11: return !f[1];
      12: return f[1];
      13: return !f[4];
      14: return f[4];
      15: return !f[5];
      16: return f[5];
      17: return !f[6];
      18: return f[6];
      19: return f[2] | f[4];
      default: return 1'b0;
    endcase
  endfunction

  // Watchdog: the sequence needs far fewer cycles than this
  initial
  begin
    #2000000;
    error_cnt++;
    finish_test;
  end

  initial
  begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    // Reset state and an unmapped address
    rd(`FLU_ADDR_FLAGS);
    `CHK(v, 32'h0)
    rd(8'h2C);
    `CHK(rs, `FLU_RESP_SLVERR)
    `CHK(v, 32'h0)
    wr(8'h2C, 32'h1);
    `CHK(rs, `FLU_RESP_SLVERR)
    // Plain direct load with saturation mode on
    wr(`FLU_ADDR_CTRL, 32'h1);
    `CHK(rs, `FLU_RESP_OKAY)
    wr(`FLU_ADDR_FLAGS, 32'h63);
    setm(32'h5, NEG);
    exec(cmd(3'h0, 2'h1, 3'h2, 3'h0, 5'h00, 5'h00), 32'h5);
    rreg(32'h2);
    `CHK(v, NEG)
    rd(`FLU_ADDR_FLAGS);
    `CHK(v, eflags(32'h63, NEG))
    // Register source holding zero
    wr(`FLU_ADDR_REGSEL, 32'h3);
    wr(`FLU_ADDR_REGDAT, ZER);
    exec(cmd(3'h0, 2'h0, 3'h1, 3'h0, 5'h00, 5'h00), 32'h3);
    rreg(32'h1);
    `CHK(v, ZER)
    rd(`FLU_ADDR_FLAGS);
    `CHK(v, eflags(eflags(32'h63, NEG), ZER))
    // Every condition code against clear and set flags
    for (int p = 0; p < 2; p++)
    begin
      for (int c = 0; c < 21; c++)
      begin
        fv = p ? 32'h7F : 32'h0;
        wr(`FLU_ADDR_FLAGS, fv);
        wr(`FLU_ADDR_REGSEL, 32'h4);
        wr(`FLU_ADDR_REGDAT, 32'h0);
        exec(cmd(3'h1, 2'h0, 3'h4, 3'h0, c[4:0], 5'h00), 32'h2);
        rreg(32'h4);
        `CHK(v, ctrue(c, fv) ? NEG : 32'h0)
        rd(`FLU_ADDR_FLAGS);
        `CHK(v, fv)
      end
    end
    // Unconditional variant keeps the flags
    exec(cmd(3'h2, 2'h0, 3'h4, 3'h0, 5'h00, 5'h00), 32'h2);
    rreg(32'h4);
    `CHK(v, NEG)
    rd(`FLU_ADDR_FLAGS);
    `CHK(v, 32'h7F)
    // False condition still updates the address register
    wr(`FLU_ADDR_AUX, 32'h1010);
    wr(`FLU_ADDR_FLAGS, 32'h4);
    exec(cmd(3'h1, 2'h2, 3'h1, 3'h0, 5'h06, 5'h08), 32'h3);
    rd(`FLU_ADDR_AUX);
    `CHK(v, 32'h1013)
    rreg(32'h1);
    `CHK(v, ZER)
    // Dual load into one register: second wins, flags kept
    wr(`FLU_ADDR_AUX, 32'h1010);
    setm(32'h10, POS);
    setm(32'h11, NEG);
    exec(cmd(3'h4, 2'h2, 3'h1, 3'h1, 5'h00, 5'h00), 32'h0100);
    rreg(32'h1);
    `CHK(v, NEG)
    rd(`FLU_ADDR_FLAGS);
    `CHK(v, 32'h4)
    // Register second source on the later revision
    wr(`FLU_ADDR_CTRL, 32'h2);
    exec(cmd(3'h4, 2'h2, 3'h5, 3'h6, 5'h00, 5'h04), 32'h0200);
    rreg(32'h5);
    `CHK(v, POS)
    rreg(32'h6);
    `CHK(v, NEG)
    // Load and store on one location: old values on both sides
    setm(32'h11, POS);
    wr(`FLU_ADDR_REGSEL, 32'h3);
    wr(`FLU_ADDR_REGDAT, 32'h1234);
    exec(cmd(3'h5, 2'h2, 3'h3, 3'h3, 5'h00, 5'h00), 32'h0101);
    rreg(32'h3);
    `CHK(v, POS)
    rd(`FLU_ADDR_MEMDAT);
    `CHK(v, 32'h1234)
    // Interlocked load refuses register and immediate sources
    for (int m = 0; m < 4; m += 3)
    begin
      exec(cmd(3'h3, m[1:0], 3'h7, 3'h0, 5'h00, 5'h00), 32'h2);
      `CHK(v[1], 1'b1)
      wr(`FLU_ADDR_STAT, 32'h2);
    end
    rreg(32'h7);
    `CHK(v, 32'h0)
    // Interlocked load stalled by pin b, then completed
    setm(32'h20, NEG);
    wr(`FLU_ADDR_FLAGS, 32'h63);
    hold_req <= 1'b1;
    repeat (4) @(posedge clk);
    wr(`FLU_ADDR_OPND, 32'h20);
    wr(`FLU_ADDR_CMD, cmd(3'h3, 2'h1, 3'h7, 3'h0, 5'h00, 5'h00));
    hold_req <= 1'b0;
    rd(`FLU_ADDR_STAT);
    `CHK(v, 32'h5)
    #1;
    `CHK(pin_a, 1'b1)
    poll;
    #1;
    `CHK(pin_a, 1'b0)
    rreg(32'h7);
    `CHK(v, NEG)
    rd(`FLU_ADDR_FLAGS);
    `CHK(v, eflags(32'h63, NEG))
    // Interlocked load with pin b low finishes at once
    setm(32'h21, ZER);
    exec(cmd(3'h3, 2'h1, 3'h6, 3'h0, 5'h00, 5'h00), 32'h21);
    `CHK(n, 1)
    rreg(32'h6);
    `CHK(v, ZER)
    rd(`FLU_ADDR_FLAGS);
    `CHK(v, eflags(eflags(32'h63, NEG), ZER))
    finish_test;
  end
endmodule
`default_nettype wire
